//--- rtl/async_serial_transceiver.sv
`timescale 1ns/1ps
`include "async_serial_transceiver_params.svh"
module async_serial_transceiver
  import async_serial_transceiver_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Mode and configuration
  input  wire logic [2:0] mode_sel,
  input  wire logic       tx_en,
  input  wire logic       rx_en,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  input  wire logic       two_stop,
  input  wire logic [1:0] clk_src_sel,
  input  wire logic [7:0] bit_rate_divider,
  input  wire logic [1:0] flow_mode,
  input  wire logic       ext_clk_pin,
  // Transmit data from software
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Receive data to software
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_read,
  // Status
  output logic            tx_empty,
  output logic            tx_irq,
  output logic            rx_irq,
  output logic            overrun_err,
  output logic            framing_err,
  output logic            parity_err,
  output logic            error_sum,
  // Serial line
  output logic            txd,
  input  wire logic       rxd,
  // Flow control pins
  input  wire logic       shared_pin_in,
  output logic            shared_pin_out,
  output logic            shared_pin_oe,
  output logic            separate_rts_pin_out,
  output logic            separate_rts_pin_oe,
  input  wire logic       gpio_out,
  input  wire logic       gpio_oe
);

  core_state_t s_q;
  core_state_t s_d;
  logic        chan_on;
  logic        src_tick;
  logic        tick16;
  logic        cts_used;
  logic        cts_ok;
  logic        rts_used;
  logic [7:0]  buf_data;
  logic        buf_valid;
  logic        buf_take;
  logic        rx_done;
  logic        rx_on;

  assign chan_on = (mode_sel != `MODE_DISABLED);
  assign rx_on   = chan_on && rx_en;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding buffer

  tx_hold_buffer u_hold (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (!chan_on),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_take)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Count source, divider and flow control terms

  // Source tick from the divided main clock or the external pin edge
  always_comb begin
    unique case (clk_src_sel)
      `SRC_DIV1:  src_tick = 1'b1;
      `SRC_DIV8:  src_tick = ((s_q.pre_cnt & `PRE_MASK8) == `PRE_RESET);
      `SRC_DIV32: src_tick = ((s_q.pre_cnt & `PRE_MASK32) == `PRE_RESET);
      `SRC_EXT:   src_tick = ext_clk_pin && !s_q.ext_q;
    endcase
  end

  // Sixteen-times bit clock after n plus one source ticks
  assign tick16 = src_tick && (s_q.div_cnt == `DIV_RESET);

  // Flow control arrangement
  assign cts_used = (flow_mode == `FLOW_CTS) || (flow_mode == `FLOW_SPLIT);
  assign rts_used = (flow_mode == `FLOW_RTS) || (flow_mode == `FLOW_SPLIT);
  assign cts_ok   = !cts_used || !shared_pin_in;

  // Load the shifter when idle, enabled, permitted and data waits
  assign buf_take = chan_on && tx_en && buf_valid && cts_ok && tick16 &&
                    (s_q.tx_state == TX_IDLE);

  // Receive frame completes at the middle of the last stop bit
  assign rx_done = rx_on && tick16 && (s_q.rx_state == RX_STOP) &&
                   (s_q.rx_ovs == `OVS_LAST) && (s_q.rx_stop2 || !two_stop);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d        = s_q;
    s_d.tx_irq = 1'b0;
    s_d.rx_irq = 1'b0;
    s_d.ext_q  = ext_clk_pin;
    s_d.pre_cnt = s_q.pre_cnt + 5'h01;

    // Bit-rate divider reload
    if (src_tick) begin
      s_d.div_cnt = (s_q.div_cnt == `DIV_RESET) ? bit_rate_divider : s_q.div_cnt - 8'h01;
    end

    // Transmitter
    if (tick16) begin
      s_d.tx_ovs = s_q.tx_ovs + 4'h1;
      unique case (s_q.tx_state)
        TX_IDLE: begin
          s_d.txd    = 1'b1;
          s_d.tx_ovs = `OVS_ZERO;
          if (buf_take) begin
            s_d.tx_shift = buf_data;
            s_d.tx_par   = parity_odd;
            s_d.tx_bit   = `BIT_ZERO;
            s_d.tx_stop2 = 1'b0;
            s_d.tx_empty = 1'b0;
            s_d.txd      = 1'b0;
            s_d.tx_state = TX_START;
          end
        end
        TX_START: begin
          if (s_q.tx_ovs == `OVS_LAST) begin
            s_d.txd      = s_q.tx_shift[0];
            s_d.tx_state = TX_DATA;
          end
        end
        TX_DATA: begin
          if (s_q.tx_ovs == `OVS_LAST) begin
            s_d.tx_par   = s_q.tx_par ^ s_q.tx_shift[0];
            s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
            s_d.tx_bit   = s_q.tx_bit + 3'h1;
            if (s_q.tx_bit == `DATA_LAST) begin
              s_d.tx_state = parity_en ? TX_PAR : TX_STOP;
              s_d.txd      = parity_en ? (s_q.tx_par ^ s_q.tx_shift[0]) : 1'b1;
            end else begin
              s_d.txd = s_q.tx_shift[1];
            end
          end
        end
        TX_PAR: begin
          if (s_q.tx_ovs == `OVS_LAST) begin
            s_d.txd      = 1'b1;
            s_d.tx_state = TX_STOP;
          end
        end
        TX_STOP: begin
          if (s_q.tx_ovs == `OVS_LAST) begin
            if (two_stop && !s_q.tx_stop2) begin
              s_d.tx_stop2 = 1'b1;
            end else begin
              s_d.tx_empty = 1'b1;
              s_d.tx_irq   = 1'b1;
              s_d.tx_state = TX_IDLE;
            end
          end
        end
      endcase
    end
    if (!chan_on) begin
      s_d.tx_state = TX_IDLE;
      s_d.txd      = 1'b1;
      s_d.tx_empty = 1'b1;
    end

    // Receiver
    if (tick16) begin
      s_d.rx_prev = rxd;
      s_d.rx_ovs  = s_q.rx_ovs + 4'h1;
      unique case (s_q.rx_state)
        RX_IDLE: begin
          s_d.rx_ovs = `OVS_ZERO;
          if (rx_on && s_q.rx_prev && !rxd) begin
            s_d.rx_state = RX_START;
            s_d.rts_n    = 1'b1;
          end
        end
        RX_START: begin
          if (s_q.rx_ovs == `OVS_MID - 4'h1) begin
            s_d.rx_ovs   = `OVS_ZERO;
            s_d.rx_bit   = `BIT_ZERO;
            s_d.rx_par   = parity_odd;
            s_d.rx_fe    = 1'b0;
            s_d.rx_stop2 = 1'b0;
            s_d.rx_state = rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_q.rx_ovs == `OVS_LAST) begin
            s_d.rx_shift = {rxd, s_q.rx_shift[7:1]};
            s_d.rx_par   = s_q.rx_par ^ rxd;
            s_d.rx_bit   = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == `DATA_LAST) begin
              s_d.rx_state = parity_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_q.rx_ovs == `OVS_LAST) begin
            s_d.rx_par   = s_q.rx_par ^ rxd;
            s_d.rx_state = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_q.rx_ovs == `OVS_LAST) begin
            s_d.rx_fe    = s_q.rx_fe || !rxd;
            s_d.rx_stop2 = 1'b1;
            if (rx_done) begin
              s_d.rx_state = RX_IDLE;
            end
          end
        end
      endcase
    end

    // Reads clear, a completing character wins over a read
    if (rx_read) begin
      s_d.rx_full = 1'b0;
      s_d.fe      = 1'b0;
      s_d.pe      = 1'b0;
    end
    if (rx_done) begin
      s_d.rx_hold = s_q.rx_shift;
      s_d.rx_full = 1'b1;
      s_d.fe      = s_q.rx_fe || !rxd;
      s_d.pe      = parity_en && s_q.rx_par;
      s_d.rts_n   = 1'b0;
      if (s_q.rx_full && !rx_read) begin
        s_d.ovr = 1'b1;
      end else begin
        s_d.rx_irq = 1'b1;
      end
    end

    // Receiver disabled reinitialises holding buffer and errors
    if (!rx_on) begin
      s_d.rx_state = RX_IDLE;
      s_d.rx_full  = 1'b0;
      s_d.ovr      = 1'b0;
      s_d.fe       = 1'b0;
      s_d.pe       = 1'b0;
      s_d.rts_n    = 1'b1;
    end else if (s_q.rx_state == RX_IDLE && !(s_q.rx_prev && !rxd && tick16)) begin
      s_d.rts_n = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.tx_state <= TX_IDLE;
      s_q.rx_state <= RX_IDLE;
      s_q.txd      <= 1'b1;
      s_q.tx_empty <= 1'b1;
      s_q.rx_prev  <= 1'b1;
      s_q.rts_n    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign txd         = s_q.txd;
  assign rx_data     = s_q.rx_hold;
  assign rx_valid    = s_q.rx_full;
  assign tx_empty    = s_q.tx_empty;
  assign tx_irq      = s_q.tx_irq;
  assign rx_irq      = s_q.rx_irq;
  assign overrun_err = s_q.ovr;
  assign framing_err = s_q.fe;
  assign parity_err  = s_q.pe;
  assign error_sum   = s_q.ovr || s_q.fe || s_q.pe;

  // Pin roles for each flow arrangement
  always_comb begin
    shared_pin_out       = gpio_out;
    shared_pin_oe        = gpio_oe;
    separate_rts_pin_out = 1'b1;
    separate_rts_pin_oe  = 1'b0;
    unique case (flow_mode)
      `FLOW_NONE: begin
        shared_pin_oe = gpio_oe;
      end
      `FLOW_CTS: begin
        shared_pin_oe = 1'b0;
      end
      `FLOW_RTS: begin
        shared_pin_out = s_q.rts_n;
        shared_pin_oe  = 1'b1;
      end
      `FLOW_SPLIT: begin
        shared_pin_oe        = 1'b0;
        separate_rts_pin_out = s_q.rts_n;
        separate_rts_pin_oe  = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_done_full;
    rx_done && s_q.rx_full && !rx_read;
  endsequence

  sequence s_done_free;
    rx_done && !s_q.rx_full;
  endsequence

  a_start_bit_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.tx_state == TX_START) |-> !txd) else $error("start bit not low");

  a_stop_field_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.tx_state == TX_STOP) |-> txd) else $error("stop bit not high");

  a_div_reload_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick16 |=> (s_q.div_cnt == $past(bit_rate_divider))) else $error("divider reload wrong");

  a_overrun_no_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_done_full |=> (overrun_err && !rx_irq)) else $error("overrun raised interrupt");

  a_rx_irq_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_done_free |=> (rx_irq && rx_valid && rx_data == $past(s_q.rx_shift))) else $error("receive handoff wrong");

  a_err_disable_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rx_on |=> !(overrun_err || framing_err || parity_err)) else $error("errors not cleared");

  a_read_clears_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rx_read && !rx_done) |=> !(framing_err || parity_err)) else $error("read left errors");

  a_err_summary: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rx_done && !rxd) |=> (framing_err && error_sum)) else $error("summary error wrong");

  a_cts_blocks_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.tx_state == TX_IDLE && cts_used && shared_pin_in) |=> (s_q.tx_state == TX_IDLE))
    else $error("sent while clear-to-send high");

  a_tx_done_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_irq |-> (tx_empty && s_q.tx_state == TX_IDLE && $past(s_q.tx_state) == TX_STOP))
    else $error("transmit completion flags wrong");

  a_flush_buffer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !chan_on |=> (!buf_valid && s_q.tx_state == TX_IDLE)) else $error("hold buffer not flushed");

endmodule // async_serial_transceiver

//--- rtl/async_serial_transceiver_params.svh
`ifndef ASYNC_SERIAL_TRANSCEIVER_PARAMS_SVH
`define ASYNC_SERIAL_TRANSCEIVER_PARAMS_SVH
// Serial mode select code that disables the channel
`define MODE_DISABLED 3'h0
// Count source selection codes
`define SRC_DIV1      2'h0
`define SRC_DIV8      2'h1
`define SRC_DIV32     2'h2
`define SRC_EXT       2'h3
// Prescaler masks for the divided main clock
`define PRE_MASK8     5'h07
`define PRE_MASK32    5'h1F
// Flow control arrangement codes
`define FLOW_NONE     2'h0
`define FLOW_CTS      2'h1
`define FLOW_RTS      2'h2
`define FLOW_SPLIT    2'h3
// Sixteen-times bit clock positions
`define OVS_LAST      4'hF
`define OVS_MID       4'h7
`define OVS_ZERO      4'h0
// Character length and reset values
`define DATA_LAST     3'h7
`define BIT_ZERO      3'h0
`define BYTE_RESET    8'h00
`define DIV_RESET     8'h00
`define PRE_RESET     5'h00
`endif

//--- rtl/async_serial_transceiver_pkg.sv
package async_serial_transceiver_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  // State of the two-entry transmit holding buffer
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
  } hold_state_t;

  // State of the transceiver core
  typedef struct packed {
    logic [4:0] pre_cnt;
    logic       ext_q;
    logic [7:0] div_cnt;
    tx_state_t  tx_state;
    logic [3:0] tx_ovs;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic       tx_par;
    logic       tx_stop2;
    logic       txd;
    logic       tx_empty;
    logic       tx_irq;
    rx_state_t  rx_state;
    logic [3:0] rx_ovs;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic       rx_par;
    logic       rx_prev;
    logic       rx_stop2;
    logic       rx_fe;
    logic [7:0] rx_hold;
    logic       rx_full;
    logic       ovr;
    logic       fe;
    logic       pe;
    logic       rx_irq;
    logic       rts_n;
  } core_state_t;

endpackage

//--- rtl/tx_hold_buffer.sv
`timescale 1ns/1ps
`include "async_serial_transceiver_params.svh"
module tx_hold_buffer
  import async_serial_transceiver_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       flush,
  // Filling side
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  // Draining side
  output logic [7:0]      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);

  hold_state_t s_q;
  hold_state_t s_d;
  logic        push;
  logic        pop;

  // Handshake terms
  assign in_ready  = (s_q.cnt != 2'h2);
  assign out_valid = (s_q.cnt != 2'h0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next state of the buffer
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = ~s_q.wp;
    end
    if (pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      s_d.wp  = 1'b0;
      s_d.rp  = 1'b0;
      s_d.cnt = 2'h0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_buf_no_overfill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.cnt != 2'h3) else $error("hold buffer count out of range");

endmodule // tx_hold_buffer

//--- verif/async_serial_transceiver_tb.sv
`timescale 1ns/1ps
`include "async_serial_transceiver_params.svh"
`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin failures++; $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module async_serial_transceiver_tb;
  // Stimulus and observed signals
  logic       ref_clk = 1'b0, rst_n = 1'b0, tx_en = 1'b1, rx_en = 1'b1, ext_clk_pin = 1'b0;
  logic       parity_en = 1'b0, parity_odd = 1'b0, two_stop = 1'b0, tx_valid = 1'b0, rx_read = 1'b0;
  logic       shared_pin_in = 1'b0, gpio_out = 1'b0, gpio_oe = 1'b0;
  logic [2:0] mode_sel = 3'h1;
  logic [1:0] clk_src_sel = `SRC_DIV1, flow_mode = `FLOW_NONE;
  logic [7:0] bit_rate_divider = 8'h01, tx_data = 8'h00, rx_data;
  logic       tx_ready, rx_valid, tx_empty, tx_irq, rx_irq, overrun_err, framing_err, parity_err, error_sum;
  logic       txd, rxd, shared_pin_out, shared_pin_oe, separate_rts_pin_out, separate_rts_pin_oe;
  logic [2:0] fmts [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
  logic [7:0] pats [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  int         divs [4] = '{1, 8, 32, 8};
  int         failures = 0, n_compared = 0, tx_irqs = 0, rx_irqs = 0, ext_div = 0, bc = 32, lows, r;

  async_serial_transceiver DUT (.ref_clk, .rst_n, .mode_sel, .tx_en, .rx_en, .parity_en, .parity_odd,
    .two_stop, .clk_src_sel, .bit_rate_divider, .flow_mode, .ext_clk_pin, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_read, .tx_empty, .tx_irq, .rx_irq, .overrun_err, .framing_err, .parity_err,
    .error_sum, .txd, .rxd, .shared_pin_in, .shared_pin_out, .shared_pin_oe, .separate_rts_pin_out,
    .separate_rts_pin_oe, .gpio_out, .gpio_oe);

  serial_peer peer (.ref_clk, .bit_clks(bc[15:0]), .parity_en, .parity_odd, .two_stop, .txd, .rxd);

  ////////////////////////////////////////////////////////////////////////////
  // Main clock and an external count source rising every eight clocks
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    ext_div <= ext_div + 1;
    ext_clk_pin <= ext_div[2];
  end

  // Count interrupt pulses away from the edge that launches them
  always @(negedge ref_clk) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic cfg(input logic [2:0] f);
    @(negedge ref_clk);
    {parity_en, parity_odd, two_stop} = f;
  endtask

  // Offer one word to the transmit buffer and hold it until taken
  task automatic tx_write(input logic [7:0] d);
    int k;
    k = 0;
    @(negedge ref_clk);
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && k < 5000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 5000) begin
      failures++;
      close_out();
    end
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask

  // One cycle read strobe
  task automatic rd();
    @(negedge ref_clk);
    rx_read = 1'b1;
    @(negedge ref_clk);
    rx_read = 1'b0;
  endtask

  // Frame received by the far side must match the word and format
  task automatic expect_frame(input logic [7:0] e);
    logic [7:0] d;
    logic       st, p;
    logic [1:0] sp;
    peer.recv(d, st, p, sp);
    if (peer.timed_out) begin
      failures++;
      close_out();
    end
    `CHK(st, 1'b0)
    `CHK(d, e)
    if (parity_en) `CHK(p, ^e ^ parity_odd)
    `CHK(sp, 2'b11)
  endtask

  // Count low samples on the transmit line over some bit times
  task automatic quiet(input int bits, output int n);
    n = 0;
    repeat (bits * bc) begin
      @(negedge ref_clk);
      if (txd !== 1'b1) n++;
    end
  endtask

  // Length of the next low stretch on the transmit line
  task automatic measure(output int n);
    int k;
    k = 0;
    n = 0;
    while (txd !== 1'b0 && k < 40000) begin
      @(negedge ref_clk);
      k++;
    end
    while (txd === 1'b0 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Held character and error flags after a reception
  task automatic rx_check(input logic [7:0] d, input logic [2:0] errs);
    ticks(2);
    `CHK(rx_valid, 1'b1)
    `CHK(rx_data, d)
    `CHK({overrun_err, framing_err, parity_err}, errs)
    `CHK(error_sum, |errs)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    ticks(16);
    rst_n = 1'b1;
    `CHK({txd, tx_empty, tx_ready, rx_valid, error_sum}, 5'b11100)
    // Each frame format, two words back to back
    foreach (fmts[i]) begin
      cfg(fmts[i]);
      fork
        begin
          tx_write(pats[i]);
          tx_write(~pats[i]);
        end
        begin
          expect_frame(pats[i]);
          expect_frame(~pats[i]);
        end
      join
    end
    ticks(bc);
    `CHK(tx_empty, 1'b1)
    `CHK(tx_irqs, 8)
    // Stall the sender, fill the buffer until it refuses, then drain
    tx_en = 1'b0;
    tx_write(8'h11);
    tx_write(8'h22);
    `CHK(tx_ready, 1'b0)
    tx_en = 1'b1;
    expect_frame(8'h11);
    expect_frame(8'h22);
    // Bit time for every count source and two divider settings
    cfg(3'b000);
    for (int s = 0; s < 4; s++) begin
      clk_src_sel = s[1:0];
      bit_rate_divider = {7'h00, s[0]};
      bc = 16 * (s % 2 + 1) * divs[s];
      fork
        tx_write(8'h01);
        expect_frame(8'h01);
        measure(lows);
      join
      `CHK((lows >= bc - 1) && (lows <= bc + 1), 1'b1)
    end
    clk_src_sel = `SRC_DIV1;
    bit_rate_divider = 8'h01;
    bc = 32;
    ticks(bc);
    // Disable in mid-frame drops the frame and the buffered word
    tx_write(8'hC3);
    tx_write(8'h5A);
    ticks(3 * bc);
    mode_sel = `MODE_DISABLED;
    ticks(2);
    mode_sel = 3'h1;
    quiet(12, lows);
    `CHK(lows, 0)
    `CHK(tx_ready, 1'b1)
    tx_write(8'h96);
    expect_frame(8'h96);
    // Clear-to-send holds the start and is looked at only per character
    flow_mode = `FLOW_CTS;
    shared_pin_in = 1'b1;
    tx_write(8'hE1);
    tx_write(8'h1E);
    quiet(3, lows);
    `CHK(lows, 0)
    shared_pin_in = 1'b0;
    fork
      expect_frame(8'hE1);
      begin
        ticks(2 * bc);
        shared_pin_in = 1'b1;
      end
    join
    quiet(3, lows);
    `CHK(lows, 0)
    shared_pin_in = 1'b0;
    expect_frame(8'h1E);
    // Request-to-send around a good reception with even parity
    cfg(3'b100);
    flow_mode = `FLOW_RTS;
    ticks(2);
    `CHK({shared_pin_oe, shared_pin_out}, 2'b10)
    fork
      peer.send(8'h3A, 1'b0, 1'b0);
      begin
        ticks(bc);
        `CHK(shared_pin_out, 1'b1)
      end
    join
    rx_check(8'h3A, 3'b000);
    `CHK(rx_irqs, 1)
    `CHK(shared_pin_out, 1'b0)
    rd();
    `CHK(rx_valid, 1'b0)
    // Parity and framing errors, cleared by a read
    peer.send(8'h3B, 1'b1, 1'b0);
    rx_check(8'h3B, 3'b001);
    rd();
    `CHK({parity_err, error_sum}, 2'b00)
    peer.send(8'h44, 1'b0, 1'b1);
    rx_check(8'h44, 3'b010);
    rd();
    `CHK({framing_err, error_sum}, 2'b00)
    // Overrun with odd parity and two stop bits
    cfg(3'b111);
    r = rx_irqs;
    peer.send(8'hC5, 1'b0, 1'b0);
    peer.send(8'h5C, 1'b0, 1'b0);
    rx_check(8'h5C, 3'b100);
    `CHK(rx_irqs, r + 1)
    rd();
    `CHK({overrun_err, error_sum}, 2'b11)
    rx_en = 1'b0;
    ticks(2);
    `CHK({rx_valid, overrun_err, error_sum}, 3'b000)
    rx_en = 1'b1;
    // Disabled mode code clears all errors
    peer.send(8'h0F, 1'b1, 1'b0);
    peer.send(8'hF0, 1'b0, 1'b1);
    rx_check(8'hF0, 3'b110);
    mode_sel = `MODE_DISABLED;
    ticks(2);
    `CHK({overrun_err, framing_err, parity_err, error_sum}, 4'h0)
    mode_sel = 3'h1;
    // Separate pins and plain port arrangements
    flow_mode = `FLOW_SPLIT;
    ticks(2);
    `CHK({separate_rts_pin_oe, separate_rts_pin_out}, 2'b10)
    flow_mode = `FLOW_NONE;
    gpio_out = 1'b1;
    gpio_oe = 1'b1;
    ticks(1);
    `CHK({shared_pin_oe, shared_pin_out}, 2'b11)
    // Send and receive at the same time
    fork
      peer.send(8'hD2, 1'b0, 1'b0);
      begin
        tx_write(8'h2D);
        expect_frame(8'h2D);
      end
    join
    rx_check(8'hD2, 3'b000);
    close_out();
  end
endmodule // async_serial_transceiver_tb

//--- verif/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input  wire logic        ref_clk,
  // Bit time in clocks and frame format
  input  wire logic [15:0] bit_clks,
  input  wire logic        parity_en,
  input  wire logic        parity_odd,
  input  wire logic        two_stop,
  // Serial lines seen from the far side
  input  wire logic        txd,
  output logic             rxd
);
  logic timed_out;

  // Idle line is high between frames
  initial begin
    rxd = 1'b1;
    timed_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive a level for one bit time
  task automatic put_bit(input logic lvl);
    rxd = lvl;
    repeat (bit_clks) @(negedge ref_clk);
  endtask

  // Send one frame; bad_par and bad_stop corrupt it on purpose
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    @(negedge ref_clk);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (parity_en) put_bit(^d ^ parity_odd ^ bad_par);
    put_bit(~bad_stop);
    if (two_stop) put_bit(1'b1);
    rxd = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Take one bit from the device one bit time later
  task automatic get_bit(output logic b);
    repeat (bit_clks) @(negedge ref_clk);
    b = txd;
  endtask

  // Receive one frame, sampling each bit near its middle
  task automatic recv(output logic [7:0] d, output logic st, output logic par, output logic [1:0] stops);
    int k;
    k = 0;
    d = 8'h00;
    par = 1'b0;
    stops = 2'b11;
    while (txd !== 1'b0 && k < 40000) begin
      @(negedge ref_clk);
      k++;
    end
    timed_out = (k >= 40000);
    repeat (bit_clks / 2) @(negedge ref_clk);
    st = txd;
    for (int i = 0; i < 8; i++) get_bit(d[i]);
    if (parity_en) get_bit(par);
    get_bit(stops[0]);
    if (two_stop) get_bit(stops[1]);
  endtask
endmodule // serial_peer
